/* File: hdl/rtmcd_device.sv */
// Radar module end: decodes test-mode frames, sets the radio mode and acknowledges.
`timescale 1ns/100ps
`default_nettype none
`include "rtmcd_cfg.svh"
module rtmcd_device
  import rtmcd_pkg::*;
#(
  parameter int BIT_CYC = `RTMCD_CLK_HZ / `RTMCD_BAUD
)(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Link toward the host.
  rtmcd_if.dev link,
  // Radio controls.
  output logic chirp_en,
  output logic cw_tone_en,
  output logic [1:0] cw_freq_sel,
  output logic sleep_en,
  output var rtmcd_mode_e mode,
  // Report of each accepted command.
  output logic cmd_seen,
  output var rtmcd_cmd_e cmd_code
);

  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
  localparam int NCMD = 7;

  // Pin synchronisers; the first stage feeds only the second.
  logic rxd_s1_q, rxd_q, mrst_s1_q, mrst_q;
  // Combined internal reset.
  logic srst;
  // Receiver state.
  rtmcd_rx_e rx_st_q;
  logic [CW-1:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_vld_q, rx_err_q;
  wire rx_tick = (rx_cnt_q == '0);
  // Frame assembly.
  logic [2:0] fr_idx_q;
  rtmcd_frame_t fr_q;
  logic fr_done_q;
  // Decode results.
  logic [NCMD-1:0] hit;
  rtmcd_cmd_e hit_code;
  wire hit_any = |hit;
  wire accept = fr_done_q && hit_any;
  // Transmitter state.
  logic tx_busy_q;
  logic [CW-1:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [2:0] tx_nb_q;
  logic [9:0] tx_sh_q;
  logic [47:0] tx_fr_q;
  wire tx_tick = (tx_cnt_q == '0);
  // Mode registers.
  logic [1:0] sel_q;

  // Two-stage synchronisers for the command line and the reset pin.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxd_s1_q <= 1'b1;
      rxd_q <= 1'b1;
      mrst_s1_q <= 1'b1;
      mrst_q <= 1'b1;
    end
    else if (ce)
    begin
      rxd_s1_q <= link.cmd_line;
      rxd_q <= rxd_s1_q;
      mrst_s1_q <= link.module_reset_n;
      mrst_q <= mrst_s1_q;
    end
  end

  // The pin reset is active low; the pull-up keeps it released when floating.
  assign srst = !rst_n || !mrst_q;

  // Receiver: start bit checked at mid-bit, eight data bits LSB first, one stop bit.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_vld_q <= 1'b0;
      rx_err_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_vld_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_cnt_q <= rx_tick ? FULL : rx_cnt_q - 1'b1;
      unique case (rx_st_q)
        RX_IDLE:
        begin
          // Falling edge: wait half a bit to reach the middle of the start bit.
          rx_cnt_q <= HALF;
          if (!rxd_q)
            rx_st_q <= RX_START;
        end
        RX_START:
          // A glitch shorter than half a bit is not a start bit.
          if (rx_tick)
            rx_st_q <= rxd_q ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rx_tick)
          begin
            rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rx_tick)
          begin
            // A low stop bit is a framing error and spoils the frame.
            rx_vld_q <= rxd_q;
            rx_err_q <= !rxd_q;
            rx_st_q <= RX_IDLE;
          end
      endcase
    end
  end

  // Frame assembly: a frame opens on the header byte and closes after seven bytes.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fr_idx_q <= '0;
      fr_q <= '0;
      fr_done_q <= 1'b0;
    end
    else if (ce)
    begin
      fr_done_q <= 1'b0;
      if (rx_err_q)
        fr_idx_q <= '0;
      else if (rx_vld_q && (fr_idx_q != '0 || rx_sh_q == `RTMCD_HDR))
      begin
        fr_q <= {fr_q[47:0], rx_sh_q};
        if (fr_idx_q == 3'(`RTMCD_FRAME_BYTES - 1))
        begin
          fr_idx_q <= '0;
          fr_done_q <= 1'b1;
        end
        else
          fr_idx_q <= fr_idx_q + 1'b1;
      end
    end
  end

  // Whole-frame compare against every known command, checksum included.
  genvar gi;
  generate
    for (gi = 0; gi < NCMD; gi++)
    begin : g_hit
      assign hit[gi] = (fr_q == rtmcd_frame(rtmcd_cmd_e'(gi)));
    end
  endgenerate

  // Encode the matching command; at most one can match.
  always_comb
  begin
    hit_code = CMD_PD_ON;
    for (int i = 0; i < NCMD; i++)
      if (hit[i])
        hit_code = rtmcd_cmd_e'(i);
  end

  // Mode register; frames that match nothing leave it untouched.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode <= MODE_PRESENCE;
      sel_q <= '0;
      cmd_seen <= 1'b0;
      cmd_code <= CMD_PD_ON;
    end
    else if (ce)
    begin
      cmd_seen <= accept;
      if (accept)
      begin
        cmd_code <= hit_code;
        unique case (hit_code)
          // Presence takes over from any mode so one mode stays active.
          CMD_PD_ON: mode <= MODE_PRESENCE;
          CMD_PD_OFF:
            if (mode == MODE_PRESENCE)
              mode <= MODE_QUIET;
          CMD_CW_LOW, CMD_CW_MID, CMD_CW_HIGH:
          begin
            // The payload byte 1, 2 or 3 selects low, mid or high tone.
            mode <= MODE_CW;
            sel_q <= fr_q[`RTMCD_PAYLOAD_LSB +: 2];
          end
          CMD_CW_OFF:
            if (mode == MODE_CW)
              mode <= MODE_QUIET;
          CMD_SLEEP: mode <= MODE_SLEEP;
        endcase
      end
    end
  end

  // Radio controls decoded from the single mode register.
  assign chirp_en = (mode == MODE_PRESENCE);
  assign cw_tone_en = (mode == MODE_CW);
  assign sleep_en = (mode == MODE_SLEEP);
  assign cw_freq_sel = cw_tone_en ? sel_q : 2'h0;

  // Acknowledge transmitter: echoes the accepted frame, first byte first.
  // A frame accepted while an echo is still going out gets no echo; the host waits anyway.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_nb_q <= '0;
      tx_sh_q <= 10'h3FF;
      tx_fr_q <= '0;
    end
    else if (ce)
    begin
      if (!tx_busy_q)
      begin
        if (accept)
        begin
          tx_busy_q <= 1'b1;
          tx_sh_q <= {1'b1, fr_q[55:48], 1'b0};
          tx_fr_q <= fr_q[47:0];
          tx_nb_q <= 3'(`RTMCD_FRAME_BYTES - 1);
          tx_bit_q <= '0;
          tx_cnt_q <= FULL;
        end
      end
      else
      begin
        tx_cnt_q <= tx_tick ? FULL : tx_cnt_q - 1'b1;
        if (tx_tick)
        begin
          if (tx_bit_q != 4'h9)
          begin
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 1'b1;
          end
          else if (tx_nb_q == '0)
            tx_busy_q <= 1'b0;
          else
          begin
            tx_sh_q <= {1'b1, tx_fr_q[47:40], 1'b0};
            tx_fr_q <= {tx_fr_q[39:0], 8'h00};
            tx_nb_q <= tx_nb_q - 1'b1;
            tx_bit_q <= '0;
          end
        end
      end
    end
  end

  // The line shows the low bit of the shifter, which idles all ones.
  assign link.ack_line = tx_sh_q[0];

endmodule : rtmcd_device
`default_nettype wire

/* File: hdl/rtmcd_cfg.svh */
// Constants of the radar test-mode command link: timing, frames and field positions.
//
// Contract
// - Reset always lands in presence detection chirping.
// - Every valid command earns an acknowledge frame; the module sends none for a frame accepted while an echo is still going out.
// - Presence-on frame resumes presence detection.
// - Presence-off frame stops chirp transmission.
// - Low tone frame starts 61.019 GHz tone.
// - Mid tone frame starts 61.249 GHz tone.
// - High tone frame starts 61.479 GHz tone.
// - Tone-off frame stops any active tone.
// - Sleep frame puts the module in deep sleep.
// - Host disables presence before enabling a tone.
// - Host disables tone before enabling presence.
// - Link runs 115200 baud, 8N1, both lines.
// - Frames are header, length, payload, checksum.
// - Module reset pin active low, pulled high.
`ifndef RTMCD_CFG_SVH
`define RTMCD_CFG_SVH

// Link timing.
`define RTMCD_CLK_HZ 100000000
`define RTMCD_BAUD 115200

// Frame layout: seven bytes, first byte sent in bits 55:48.
`define RTMCD_FRAME_BYTES 7
`define RTMCD_HDR 8'hD9
`define RTMCD_PAYLOAD_LSB 16

// Command frames.
`define RTMCD_FRM_PD_ON 56'hD9_0A_01_00_01_28_C1
`define RTMCD_FRM_PD_OFF 56'hD9_0A_01_00_00_09_D1
`define RTMCD_FRM_CW_LOW 56'hD9_0B_01_00_01_9C_B7
`define RTMCD_FRM_CW_MID 56'hD9_0B_01_00_02_FF_87
`define RTMCD_FRM_CW_HIGH 56'hD9_0B_01_00_03_DE_97
`define RTMCD_FRM_CW_OFF 56'hD9_0B_01_00_00_BD_A7
`define RTMCD_FRM_SLEEP 56'hD9_0E_01_00_01_D9_0B

// Host gives up on an acknowledge after this many cycles (20 byte times).
`define RTMCD_ACK_WAIT_CYC 173600

`endif

/* File: hdl/rtmcd_pkg.sv */
// Types and frame lookup shared by both ends of the command link.
`include "rtmcd_cfg.svh"
package rtmcd_pkg;

  // The seven test-mode commands.
  typedef enum logic [2:0] {
    CMD_PD_ON,
    CMD_PD_OFF,
    CMD_CW_LOW,
    CMD_CW_MID,
    CMD_CW_HIGH,
    CMD_CW_OFF,
    CMD_SLEEP
  } rtmcd_cmd_e;

  // Radio modes; exactly one is active.
  typedef enum logic [1:0] {
    MODE_PRESENCE,
    MODE_QUIET,
    MODE_CW,
    MODE_SLEEP
  } rtmcd_mode_e;

  // Serial receiver states.
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rtmcd_rx_e;

  // Host sequencer states.
  typedef enum logic [1:0] {
    H_IDLE,
    H_SEND,
    H_WAIT
  } rtmcd_host_e;

  typedef logic [55:0] rtmcd_frame_t;

  // Maps a command to its full seven-byte frame.
  function automatic rtmcd_frame_t rtmcd_frame(input rtmcd_cmd_e c);
    rtmcd_frame_t f;
    unique case (c)
      CMD_PD_ON: f = `RTMCD_FRM_PD_ON;
      CMD_PD_OFF: f = `RTMCD_FRM_PD_OFF;
      CMD_CW_LOW: f = `RTMCD_FRM_CW_LOW;
      CMD_CW_MID: f = `RTMCD_FRM_CW_MID;
      CMD_CW_HIGH: f = `RTMCD_FRM_CW_HIGH;
      CMD_CW_OFF: f = `RTMCD_FRM_CW_OFF;
      CMD_SLEEP: f = `RTMCD_FRM_SLEEP;
      default: f = '0;
    endcase
    return f;
  endfunction : rtmcd_frame

endpackage : rtmcd_pkg

/* File: hdl/rtmcd_if.sv */
// Serial command link and reset pin between host and radar module.
`timescale 1ns/100ps
`default_nettype none
interface rtmcd_if;
  // Host to module command line, idle high.
  logic cmd_line;
  // Module to host acknowledge line, idle high.
  logic ack_line;
  // Host drive of the reset pin; enable is low while driving.
  logic rst_o;
  logic rst_oe;
  // Pin level: the internal pull-up holds it high when undriven.
  logic module_reset_n;
  assign module_reset_n = rst_oe ? 1'b1 : rst_o;

  modport dev (input cmd_line, input module_reset_n, output ack_line);
  modport hst (output cmd_line, output rst_o, output rst_oe, input ack_line);
endinterface : rtmcd_if
`default_nettype wire

/* File: hdl/rtmcd_host.sv */
// Host end: sends one test-mode frame per request and waits for its acknowledge.
`timescale 1ns/100ps
`default_nettype none
`include "rtmcd_cfg.svh"
module rtmcd_host
  import rtmcd_pkg::*;
#(
  parameter int BIT_CYC = `RTMCD_CLK_HZ / `RTMCD_BAUD,
  parameter int ACK_WAIT_CYC = `RTMCD_ACK_WAIT_CYC
)(
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Link toward the module.
  rtmcd_if.hst link,
  // Command request.
  input wire logic cmd_valid,
  input var rtmcd_cmd_e cmd_code,
  output logic cmd_ready,
  // Module reset request, held as long as the pin must stay low.
  input wire logic reset_req,
  // Result of each request.
  output logic ack_valid,
  output logic ack_ok
);

  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

  // Sequencer and timers.
  rtmcd_host_e st_q;
  logic [CW-1:0] cnt_q, rcnt_q;
  logic [$clog2(ACK_WAIT_CYC + 1)-1:0] wait_q;
  // Transmit shifter; idles all ones.
  logic [9:0] sh_q;
  logic [3:0] bit_q;
  logic [2:0] nb_q;
  rtmcd_frame_t sent_q, tx_fr_q, ack_fr_q;
  // Acknowledge receiver.
  logic rxd_s1_q, rxd_q;
  rtmcd_rx_e rx_st_q;
  logic [3:0] rbit_q;
  logic [7:0] rsh_q;
  logic [2:0] rnb_q;
  logic rst_oe_q;
  // Frame of the requested command; only its top byte goes into the first shifter load.
  rtmcd_frame_t req_fr;
  wire tick = (cnt_q == '0);
  wire rtick = (rcnt_q == '0);

  assign req_fr = rtmcd_frame(cmd_code);
  assign cmd_ready = (st_q == H_IDLE);
  assign link.cmd_line = sh_q[0];
  // The pin is only ever pulled low; the enable releases it to the pull-up.
  assign link.rst_o = 1'b0;
  assign link.rst_oe = rst_oe_q;

  // Reset pin drive and acknowledge-line synchroniser.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rst_oe_q <= 1'b1;
      rxd_s1_q <= 1'b1;
      rxd_q <= 1'b1;
    end
    else if (ce)
    begin
      rst_oe_q <= !reset_req;
      rxd_s1_q <= link.ack_line;
      rxd_q <= rxd_s1_q;
    end
  end

  // Sequencer: send seven bytes, then wait for a seven-byte echo or time out.
  // Requests are one at a time, so tone and presence changes keep their order.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      wait_q <= '0;
      sh_q <= 10'h3FF;
      bit_q <= '0;
      nb_q <= '0;
      sent_q <= '0;
      tx_fr_q <= '0;
      ack_valid <= 1'b0;
      ack_ok <= 1'b0;
    end
    else if (ce)
    begin
      ack_valid <= 1'b0;
      cnt_q <= tick ? FULL : cnt_q - 1'b1;
      unique case (st_q)
        H_IDLE:
          if (cmd_valid)
          begin
            sent_q <= req_fr;
            tx_fr_q <= req_fr << 8;
            // Take exactly the first byte, so the stop bit above it stays high.
            sh_q <= {1'b1, req_fr[55:48], 1'b0};
            nb_q <= 3'(`RTMCD_FRAME_BYTES - 1);
            bit_q <= '0;
            cnt_q <= FULL;
            st_q <= H_SEND;
          end
        H_SEND:
          if (tick)
          begin
            if (bit_q != 4'h9)
            begin
              sh_q <= {1'b1, sh_q[9:1]};
              bit_q <= bit_q + 1'b1;
            end
            else if (nb_q == '0)
            begin
              st_q <= H_WAIT;
              wait_q <= '0;
            end
            else
            begin
              sh_q <= {1'b1, tx_fr_q[55:48], 1'b0};
              tx_fr_q <= tx_fr_q << 8;
              nb_q <= nb_q - 1'b1;
              bit_q <= '0;
            end
          end
        H_WAIT:
        begin
          wait_q <= wait_q + 1'b1;
          if (rnb_q == 3'(`RTMCD_FRAME_BYTES) - 3'h1 && rx_st_q == RX_STOP && rtick && rxd_q)
          begin
            // Last echo byte closes: the frame is still one byte short here.
            ack_valid <= 1'b1;
            ack_ok <= ({ack_fr_q[47:0], rsh_q} == sent_q);
            st_q <= H_IDLE;
          end
          else if (wait_q == ($bits(wait_q))'(ACK_WAIT_CYC - 1))
          begin
            ack_valid <= 1'b1;
            ack_ok <= 1'b0;
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Acknowledge receiver; bytes gather only while a reply is awaited.
  always_ff @(posedge clk)
  begin
    if (!rst_n || st_q != H_WAIT)
    begin
      rx_st_q <= RX_IDLE;
      rcnt_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      rnb_q <= '0;
      ack_fr_q <= '0;
    end
    else if (ce)
    begin
      rcnt_q <= rtick ? FULL : rcnt_q - 1'b1;
      unique case (rx_st_q)
        RX_IDLE:
        begin
          rcnt_q <= HALF;
          rbit_q <= '0;
          if (!rxd_q)
            rx_st_q <= RX_START;
        end
        RX_START:
          if (rtick)
            rx_st_q <= rxd_q ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (rtick)
          begin
            rsh_q <= {rxd_q, rsh_q[7:1]};
            rbit_q <= rbit_q + 1'b1;
            if (rbit_q == 4'h7)
              rx_st_q <= RX_STOP;
          end
        RX_STOP:
          if (rtick)
          begin
            if (rxd_q)
            begin
              ack_fr_q <= {ack_fr_q[47:0], rsh_q};
              rnb_q <= rnb_q + 1'b1;
            end
            rx_st_q <= RX_IDLE;
          end
      endcase
    end
  end

endmodule : rtmcd_host
`default_nettype wire

/* File: sim/rtmcd_link_props.sv */
// Concurrent checks on the command link wires and the radio mode outputs.
`timescale 1ns/100ps
`default_nettype none
module rtmcd_link_props
  import rtmcd_pkg::*;
#(
  parameter int BIT_CYC = 16
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link wires.
  input wire logic cmd_line,
  input wire logic ack_line,
  input wire logic module_reset_n,
  // Radio outputs of the module end.
  input wire logic chirp_en,
  input wire logic cw_tone_en,
  input wire logic [1:0] cw_freq_sel,
  input wire logic sleep_en,
  input var rtmcd_mode_e mode,
  input wire logic cmd_seen,
  input var rtmcd_cmd_e cmd_code
);
  default clocking cb @(posedge clk);
  endclocking

  // Length of the current low run on the command line, so bit times can be judged.
  logic [15:0] low_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n || cmd_line)
      low_q <= 16'h0000;
    else
      low_q <= low_q + 16'h0001;
  end

  AST_RESET_PRESENCE: assert property (!rst_n |=> mode == MODE_PRESENCE && chirp_en)
    else $error("reset did not land in presence mode");
  AST_RESET_IDLE: assert property (!rst_n |=> cmd_line && ack_line)
    else $error("serial lines not idle high after reset");
  AST_PIN_RESET: assert property (disable iff (!rst_n) !module_reset_n [*5] |=> mode == MODE_PRESENCE)
    else $error("reset pin did not restore presence mode");
  AST_ONE_MODE: assert property (disable iff (!rst_n) (int'(chirp_en) + int'(cw_tone_en) + int'(sleep_en)) <= 1
    && chirp_en == (mode == MODE_PRESENCE) && sleep_en == (mode == MODE_SLEEP))
    else $error("radio modes overlap");
  AST_TONE_FREQ: assert property (disable iff (!rst_n) cw_tone_en == (cw_freq_sel != 2'h0))
    else $error("tone enable and frequency disagree");
  AST_MID_TONE: assert property (disable iff (!rst_n) cmd_seen && cmd_code == CMD_CW_MID
    |-> cw_tone_en && cw_freq_sel == 2'h2)
    else $error("mid tone command not applied");
  AST_PD_CMD: assert property (disable iff (!rst_n) cmd_seen && cmd_code == CMD_PD_ON |-> chirp_en && !cw_tone_en)
    else $error("presence command not applied");
  AST_SLEEP_CMD: assert property (disable iff (!rst_n) cmd_seen && cmd_code == CMD_SLEEP |-> sleep_en)
    else $error("sleep command not applied");
  AST_ECHO: assert property (disable iff (!rst_n) cmd_seen |=> !ack_line)
    else $error("acknowledge did not start");
  AST_HOLD_MODE: assert property (disable iff (!rst_n) module_reset_n [*5] ##1 (!cmd_seen && module_reset_n)
    |-> $stable(mode))
    else $error("mode changed without an accepted command");
  AST_BIT_TIME: assert property (disable iff (!rst_n) $rose(cmd_line) |-> (low_q % BIT_CYC) == 0)
    else $error("low run on command line not whole bit times");
endmodule : rtmcd_link_props
`default_nettype wire

/* File: sim/testbench.sv */
// Testbench joining host and module ends, plus a lone module end driven by hand.
`timescale 1ns/100ps
`default_nettype none
`include "rtmcd_cfg.svh"
module testbench
  import rtmcd_pkg::*;
;
  // Short bit time keeps the run brief; the wait covers 20 bytes at that rate.
  localparam int BC = 16;
  localparam int ACKW = 3500;
  logic clk, rst_n, cmd_valid, cmd_ready, reset_req, ack_valid, ack_ok, drv_line;
  logic chirp_en, cw_tone_en, sleep_en, cmd_seen;
  logic [1:0] cw_freq_sel;
  rtmcd_cmd_e cmd_code, dev_code;
  rtmcd_mode_e mode, mode2;
  int err_total = 0;
  int n_compared = 0;
  rtmcd_if lnk();
  rtmcd_if lnk2();
  // The lone end never sees its reset pin driven, so the pull-up holds it high.
  assign lnk2.cmd_line = drv_line;
  assign lnk2.rst_o = 1'b0;
  assign lnk2.rst_oe = 1'b1;

  rtmcd_device #(.BIT_CYC(BC)) u_rtmcd_device (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lnk),
    .chirp_en(chirp_en), .cw_tone_en(cw_tone_en), .cw_freq_sel(cw_freq_sel), .sleep_en(sleep_en),
    .mode(mode), .cmd_seen(cmd_seen), .cmd_code(dev_code));
  rtmcd_host #(.BIT_CYC(BC), .ACK_WAIT_CYC(ACKW)) u_rtmcd_host (.clk(clk), .rst_n(rst_n), .ce(1'b1),
    .link(lnk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready),
    .reset_req(reset_req), .ack_valid(ack_valid), .ack_ok(ack_ok));
  rtmcd_device #(.BIT_CYC(BC)) u_rtmcd_device_2 (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(lnk2),
    .chirp_en(), .cw_tone_en(), .cw_freq_sel(), .sleep_en(), .mode(mode2), .cmd_seen(), .cmd_code());
  rtmcd_link_props #(.BIT_CYC(BC)) u_rtmcd_link_props (.clk(clk), .rst_n(rst_n), .cmd_line(lnk.cmd_line),
    .ack_line(lnk.ack_line), .module_reset_n(lnk.module_reset_n), .chirp_en(chirp_en),
    .cw_tone_en(cw_tone_en), .cw_freq_sel(cw_freq_sel), .sleep_en(sleep_en), .mode(mode),
    .cmd_seen(cmd_seen), .cmd_code(dev_code));

  // Free-running clock at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check_bits(input logic [55:0] got, input logic [55:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bits

  task automatic check_mode(input rtmcd_mode_e got, input rtmcd_mode_e exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_mode

  task automatic report_and_stop;
    $display("Compared %0d values, %0d wrong", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Line picker: 0 command line, 1 acknowledge line, 2 acknowledge of the lone end.
  function automatic logic line_at(input int sel);
    return (sel == 0) ? lnk.cmd_line : (sel == 1) ? lnk.ack_line : lnk2.ack_line;
  endfunction : line_at

  // Receives seven 8N1 bytes, sampling mid-bit on falling edges where lines are settled.
  task automatic capture(input int sel, output logic [55:0] f);
    int n;
    f = '0;
    for (int b = 0; b < 7; b++)
    begin
      n = 0;
      while (line_at(sel) !== 1'b0 && n < 4 * ACKW)
      begin
        @(negedge clk);
        n++;
      end
      repeat (BC / 2) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BC) @(negedge clk);
        f[48 - 8 * b + i] = line_at(sel);
      end
      repeat (BC) @(negedge clk);
    end
  endtask : capture

  // Sends a frame to the lone end, least significant bit first.
  task automatic drv_frame(input logic [55:0] f);
    logic [9:0] sh;
    for (int b = 0; b < 7; b++)
    begin
      sh = {1'b1, f[55 - 8 * b -: 8], 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        drv_line = sh[i];
        repeat (BC) @(negedge clk);
      end
    end
  endtask : drv_frame

  // One host request: watch both wires and wait for the host's verdict.
  task automatic send_cmd(input rtmcd_cmd_e c, input logic [55:0] f);
    logic [55:0] sent;
    logic [55:0] echo;
    int n;
    cmd_code = c;
    check_bits(56'(cmd_ready), 56'h1);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    check_bits(56'(cmd_ready), 56'h0);
    n = 0;
    fork
      capture(0, sent);
      capture(1, echo);
      while (ack_valid !== 1'b1 && n < 4 * ACKW)
      begin
        @(negedge clk);
        n++;
      end
    join
    check_bits(56'(n < 4 * ACKW), 56'h1);
    check_bits(56'(ack_ok), 56'h1);
    check_bits(sent, f);
    check_bits(echo, f);
  endtask : send_cmd

  task automatic test_reset_state;
    check_mode(mode, MODE_PRESENCE);
    check_bits(56'({chirp_en, cw_tone_en, sleep_en}), 56'h4);
  endtask : test_reset_state

  // Every tone in turn, entered and left in the documented order.
  task automatic test_tone_cycle;
    logic [55:0] tone [3];
    tone = '{`RTMCD_FRM_CW_LOW, `RTMCD_FRM_CW_MID, `RTMCD_FRM_CW_HIGH};
    send_cmd(CMD_PD_OFF, `RTMCD_FRM_PD_OFF);
    check_mode(mode, MODE_QUIET);
    for (int i = 0; i < 3; i++)
    begin
      send_cmd(rtmcd_cmd_e'(int'(CMD_CW_LOW) + i), tone[i]);
      check_bits(56'({chirp_en, cw_tone_en, cw_freq_sel}), 56'(5 + i));
      send_cmd(CMD_CW_OFF, `RTMCD_FRM_CW_OFF);
      check_bits(56'({chirp_en, cw_tone_en, cw_freq_sel}), 56'h0);
    end
    send_cmd(CMD_PD_ON, `RTMCD_FRM_PD_ON);
    check_mode(mode, MODE_PRESENCE);
  endtask : test_tone_cycle

  // Sleep, then leave it through the reset pin.
  task automatic test_sleep_pin;
    send_cmd(CMD_SLEEP, `RTMCD_FRM_SLEEP);
    check_bits(56'({chirp_en, cw_tone_en, sleep_en}), 56'h1);
    reset_req = 1'b1;
    repeat (10) @(negedge clk);
    check_bits(56'(lnk.module_reset_n), 56'h0);
    reset_req = 1'b0;
    repeat (10) @(negedge clk);
    check_bits(56'(lnk.module_reset_n), 56'h1);
    check_mode(mode, MODE_PRESENCE);
    send_cmd(CMD_SLEEP, `RTMCD_FRM_SLEEP);
    check_mode(mode, MODE_SLEEP);
  endtask : test_sleep_pin

  // A corrupt checksum must be dropped silently; a good frame right after is served.
  task automatic test_unknown;
    logic [55:0] echo;
    int lows;
    lows = 0;
    fork
      drv_frame(56'hD9_0A_01_00_00_09_D2);
      repeat (90 * BC)
      begin
        @(negedge clk);
        if (lnk2.ack_line !== 1'b1)
          lows++;
      end
    join
    check_bits(56'(lows), 56'h0);
    check_mode(mode2, MODE_PRESENCE);
    fork
      drv_frame(`RTMCD_FRM_PD_OFF);
      capture(2, echo);
    join
    check_bits(echo, `RTMCD_FRM_PD_OFF);
    check_mode(mode2, MODE_QUIET);
  endtask : test_unknown

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = CMD_PD_ON;
    reset_req = 1'b0;
    drv_line = 1'b1;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    test_reset_state();
    test_tone_cycle();
    test_sleep_pin();
    test_unknown();
    report_and_stop();
  end

  // Watchdog: about twice the expected run length of some 26000 cycles.
  initial
  begin
    #600000;
    err_total++;
    $display("Watchdog expired at %0t", $time);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
